// file: cap_slave_port.sv
// device end of the accelerator port
// Functional notes
// - 128-bit read and write data, line-oriented
// - master uses only cacheable attribute codes; this master passes any req_attr through
// - coherency lookup in shared and core caches
// - writes stash to shared or chosen core
// - no exclusive access, no lock signals
// - no barriers; response after global observation
// - no size signal; assume 16-byte beats
// - assume incrementing burst, read snoop zero
// - reads: 16B aligned or 64B aligned
// - 16B writes: length 0, partial types
// - 64B writes: length 3, full needs strobes
// - partial-stash write handled as partial write
// - full stash: 64B, aligned, all strobes
// - dataless stash: length 3, no beats
// - target core on id bits 3:1
// - violations answered with slave error
// - partial writes done as read-modify-write
// - untargeted: allocate on write-allocate bit
// - untargeted full stash equals full write
// - targeted full or dataless stash allocates to core
// - limits 33 writes, 33 reads, 34 total
// - master keeps one outstanding per id
`timescale 1ns/100ps
`default_nettype none
module cap_slave_port #(
    parameter int MAX_WR = cap_pkg::CAP_MAX_WR,
    parameter int MAX_RD = cap_pkg::CAP_MAX_RD,
    parameter int MAX_ALL = cap_pkg::CAP_MAX_ALL
) (
    input wire logic clk, // system clock
    input wire logic srst, // synchronous reset, active high
    cap_if.dev port, // accelerator side, no lock signals
    output logic lookup_valid, // coherency lookup pulse
    output logic [cap_pkg::CAP_ADDR_W-1:0] lookup_addr, // line looked up
    output logic wr_commit_valid, // write committed pulse
    output logic [cap_pkg::CAP_ADDR_W-1:0] wr_commit_addr, // committed line address
    output cap_pkg::cap_dest_t wr_commit_dest, // shared cache, core or memory
    output logic [2:0] wr_commit_core, // target core number
    output logic wr_commit_rmw, // write was read-modify-write
    input wire logic [cap_pkg::CAP_DATA_W-1:0] mem_rd_data, // line data for reads
    output logic [5:0] rd_outstanding, // reads in flight
    output logic [5:0] wr_outstanding // writes in flight
);
    import cap_pkg::*;

    function automatic logic attr_ok(input logic [3:0] a);
        attr_ok = a inside {CAP_ATTR_A, CAP_ATTR_B, CAP_ATTR_C};
    endfunction : attr_ok

    function automatic logic shape_ok(input logic [CAP_LEN_W-1:0] len,
                                      input logic [5:0] low);
        shape_ok = ((len == CAP_LEN_ONE) && ((low & CAP_A16_MASK) == 6'h00)) ||
                   ((len == CAP_LEN_FOUR) && ((low & CAP_A64_MASK) == 6'h00));
    endfunction : shape_ok

    typedef enum {W_IDLE, W_DATA, W_RMW, W_RESP} cap_wst_t;
    typedef enum {R_IDLE, R_DATA} cap_rst_t;

    cap_wst_t wst_r;
    cap_rst_t rst_r;
    logic [5:0] wcnt_r, rcnt_r;
    logic [CAP_ADDR_W-1:0] waddr_r;
    logic [CAP_ID_W-1:0] wid_r, rid_r;
    logic [3:0] wtype_r, wattr_r;
    logic wtgt_en_r, werr_r, rerr_r, wfull_r;
    logic [2:0] wcore_r;
    logic [1:0] rbeat_r, rlen_r, rmw_cnt_r;
    logic aw_take, ar_take, b_done, r_done, w_take;
    logic wr_room, rd_room, aw_legal, is_ptl, is_fullw, is_fstash, is_dl;

    // write type decode
    assign is_ptl = port.wr_txn_type inside {CAP_WR_UNIQUE_PTL, CAP_WR_UNIQUE_PTL_STASH};
    assign is_fullw = port.wr_txn_type == CAP_WR_UNIQUE_FULL;
    assign is_fstash = port.wr_txn_type == CAP_WR_UNIQUE_FULL_STASH;
    assign is_dl = port.wr_txn_type inside {CAP_STASH_ONCE_SHARED, CAP_STASH_ONCE_UNIQUE};
    // write request legality
    assign aw_legal = attr_ok(port.wr_cache_attr) && shape_ok(port.wr_burst_len,
                      port.wr_addr[5:0]) &&
                      (is_ptl || ((is_fullw || is_fstash || is_dl) &&
                      port.wr_burst_len == CAP_LEN_FOUR));

    // limits gate address ready
    assign wr_room = (32'(wcnt_r) < MAX_WR) && (32'(wcnt_r) + 32'(rcnt_r) < MAX_ALL);
    assign rd_room = (32'(rcnt_r) < MAX_RD) && (32'(wcnt_r) + 32'(rcnt_r) < MAX_ALL);
    assign port.aw_ready = (wst_r == W_IDLE) && wr_room;
    assign port.ar_ready = (rst_r == R_IDLE) && rd_room && !(port.aw_valid && port.aw_ready
                           );
    assign aw_take = port.aw_valid && port.aw_ready;
    assign ar_take = port.ar_valid && port.ar_ready;
    assign w_take = port.w_valid && port.w_ready;
    assign b_done = port.b_valid && port.b_ready;
    assign r_done = port.r_valid && port.r_ready && port.r_last;
    assign port.w_ready = wst_r == W_DATA;
    assign port.b_valid = wst_r == W_RESP;
    assign port.r_valid = rst_r == R_DATA;
    assign port.r_last = rbeat_r == rlen_r;
    assign rd_outstanding = rcnt_r;
    assign wr_outstanding = wcnt_r;

    // in-flight counters
    always_ff @(posedge clk) begin
        if (srst) begin
            wcnt_r <= '0;
            rcnt_r <= '0;
        end else begin
            wcnt_r <= wcnt_r + 6'(aw_take) - 6'(b_done);
            rcnt_r <= rcnt_r + 6'(ar_take) - 6'(r_done);
        end
    end

    // write sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            wst_r <= W_IDLE;
            waddr_r <= '0;
            wid_r <= '0;
            wtype_r <= '0;
            wattr_r <= '0;
            wtgt_en_r <= 1'b0;
            wcore_r <= '0;
            werr_r <= 1'b0;
            wfull_r <= 1'b1;
            rmw_cnt_r <= '0;
        end else begin
            unique case (wst_r)
                W_IDLE: if (aw_take) begin
                    waddr_r <= port.wr_addr;
                    wid_r <= port.aw_id;
                    wtype_r <= port.wr_txn_type;
                    wattr_r <= port.wr_cache_attr;
                    wtgt_en_r <= port.stash_target_enable;
                    wcore_r <= port.stash_target_id[3:1];
                    werr_r <= !aw_legal;
                    wfull_r <= 1'b1;
                    wst_r <= is_dl ? W_RESP : W_DATA;
                end
                W_DATA: if (w_take) begin
                    if (port.wr_byte_strobes != CAP_STRB_ALL) begin
                        wfull_r <= 1'b0;
                    end
                    if (port.w_last) begin
                        rmw_cnt_r <= '0;
                        wst_r <= W_RMW;
                    end
                end
                W_RMW: begin
                    // merge stage
                    rmw_cnt_r <= rmw_cnt_r + 2'h1;
                    if (wtype_r inside {CAP_WR_UNIQUE_FULL, CAP_WR_UNIQUE_FULL_STASH}) begin
                        if (!wfull_r) begin
                            werr_r <= 1'b1;
                        end
                        wst_r <= W_RESP;
                    end else if (32'(rmw_cnt_r) == CAP_RMW_CYC - 1) begin
                        wst_r <= W_RESP;
                    end
                end
                W_RESP: if (b_done) begin
                    wst_r <= W_IDLE;
                end
            endcase
        end
    end

    // lookup and commit pulses
    always_ff @(posedge clk) begin
        if (srst) begin
            lookup_valid <= 1'b0;
            lookup_addr <= '0;
            wr_commit_valid <= 1'b0;
            wr_commit_addr <= '0;
            wr_commit_dest <= CAP_DEST_SHARED;
            wr_commit_core <= '0;
            wr_commit_rmw <= 1'b0;
        end else begin
            lookup_valid <= (aw_take && aw_legal) || (ar_take && attr_ok(port.rd_cache_attr)
                            && shape_ok(port.rd_burst_len, port.rd_addr[5:0]));
            lookup_addr <= aw_take ? port.wr_addr : port.rd_addr;
            wr_commit_valid <= (wst_r == W_RESP) && b_done && !werr_r;
            wr_commit_addr <= waddr_r;
            wr_commit_core <= wcore_r;
            wr_commit_rmw <= wtype_r inside {CAP_WR_UNIQUE_PTL, CAP_WR_UNIQUE_PTL_STASH};
            if (wtgt_en_r && wtype_r != CAP_WR_UNIQUE_PTL_STASH) begin
                wr_commit_dest <= CAP_DEST_CORE;
            end else if (wattr_r[CAP_ATTR_WALLOC_BIT]) begin
                wr_commit_dest <= CAP_DEST_SHARED;
            end else begin
                wr_commit_dest <= CAP_DEST_MEMORY;
            end
        end
    end

    assign port.b_id = wid_r;
    assign port.wr_resp = werr_r ? CAP_RESP_SLVERR : CAP_RESP_OKAY;

    // read sequencer: 16-byte incrementing beats
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_r <= R_IDLE;
            rid_r <= '0;
            rerr_r <= 1'b0;
            rbeat_r <= '0;
            rlen_r <= '0;
        end else begin
            unique case (rst_r)
                R_IDLE: if (ar_take) begin
                    rid_r <= port.ar_id;
                    rerr_r <= !(attr_ok(port.rd_cache_attr) &&
                              shape_ok(port.rd_burst_len, port.rd_addr[5:0]));
                    rlen_r <= port.rd_burst_len[1:0];
                    rbeat_r <= '0;
                    rst_r <= R_DATA;
                end
                R_DATA: if (port.r_valid && port.r_ready) begin
                    rbeat_r <= rbeat_r + 2'h1;
                    if (port.r_last) begin
                        rst_r <= R_IDLE;
                    end
                end
            endcase
        end
    end

    assign port.r_id = rid_r;
    assign port.rd_resp = rerr_r ? CAP_RESP_SLVERR : CAP_RESP_OKAY;
    assign port.r_data = rerr_r ? '0 : mem_rd_data;
endmodule : cap_slave_port
`default_nettype wire

// file: cap_pkg.sv
// package for the coherent accelerator port: widths, encodings, limits
package cap_pkg;
    localparam int CAP_DATA_W = 128;
    localparam int CAP_STRB_W = 16;
    localparam int CAP_ADDR_W = 40;
    localparam int CAP_ID_W = 6;
    localparam int CAP_LEN_W = 8;
    localparam logic [7:0] CAP_LEN_ONE = 8'h00;
    localparam logic [7:0] CAP_LEN_FOUR = 8'h03;
    localparam logic [3:0] CAP_ATTR_A = 4'h7;
    localparam logic [3:0] CAP_ATTR_B = 4'hB;
    localparam logic [3:0] CAP_ATTR_C = 4'hF;
    localparam int CAP_ATTR_WALLOC_BIT = 3;
    localparam logic [2:0] CAP_SIZE_FIXED = 3'h4;
    localparam logic [1:0] CAP_BURST_INCR = 2'h1;
    localparam logic [3:0] CAP_RD_SNOOP = 4'h0;
    localparam logic [5:0] CAP_A16_MASK = 6'h0F;
    localparam logic [5:0] CAP_A64_MASK = 6'h3F;
    localparam logic [1:0] CAP_RESP_OKAY = 2'h0;
    localparam logic [1:0] CAP_RESP_SLVERR = 2'h2;
    localparam int CAP_MAX_WR = 33;
    localparam int CAP_MAX_RD = 33;
    localparam int CAP_MAX_ALL = 34;
    localparam int CAP_CNT_W = 6;
    localparam int CAP_BUF_DEPTH = 2;
    localparam int CAP_RMW_CYC = 2;
    localparam logic [CAP_STRB_W-1:0] CAP_STRB_ALL = 16'hFFFF;
    // write transaction types
    typedef enum logic [3:0] {
        CAP_WR_UNIQUE_PTL = 4'h0,
        CAP_WR_UNIQUE_FULL = 4'h1,
        CAP_WR_UNIQUE_PTL_STASH = 4'h8,
        CAP_WR_UNIQUE_FULL_STASH = 4'h9,
        CAP_STASH_ONCE_SHARED = 4'hC,
        CAP_STASH_ONCE_UNIQUE = 4'hD
    } cap_wtype_t;
    // where a write ends up
    typedef enum logic [1:0] {
        CAP_DEST_SHARED,
        CAP_DEST_CORE,
        CAP_DEST_MEMORY
    } cap_dest_t;
endpackage : cap_pkg

// file: cap_if.sv
// interface joining the accelerator master and the coherent slave port
`timescale 1ns/100ps
`default_nettype none
interface cap_if;
    import cap_pkg::*;
    logic aw_valid;
    logic aw_ready;
    logic [CAP_ADDR_W-1:0] wr_addr;
    logic [CAP_LEN_W-1:0] wr_burst_len;
    logic [3:0] wr_cache_attr;
    logic [3:0] wr_txn_type;
    logic [1:0] wr_share_domain;
    logic stash_target_enable;
    logic [3:0] stash_target_id;
    logic [CAP_ID_W-1:0] aw_id;
    logic w_valid;
    logic w_ready;
    logic [CAP_DATA_W-1:0] w_data;
    logic [CAP_STRB_W-1:0] wr_byte_strobes;
    logic w_last;
    logic b_valid;
    logic b_ready;
    logic [1:0] wr_resp;
    logic [CAP_ID_W-1:0] b_id;
    logic ar_valid;
    logic ar_ready;
    logic [CAP_ADDR_W-1:0] rd_addr;
    logic [CAP_LEN_W-1:0] rd_burst_len;
    logic [3:0] rd_cache_attr;
    logic [1:0] rd_share_domain;
    logic [CAP_ID_W-1:0] ar_id;
    logic r_valid;
    logic r_ready;
    logic [CAP_DATA_W-1:0] r_data;
    logic [1:0] rd_resp;
    logic r_last;
    logic [CAP_ID_W-1:0] r_id;
    modport dev (
        input aw_valid, wr_addr, wr_burst_len, wr_cache_attr, wr_txn_type, wr_share_domain,
        input stash_target_enable, stash_target_id, aw_id, w_valid, w_data,
        input wr_byte_strobes, w_last, b_ready, ar_valid, rd_addr, rd_burst_len,
        input rd_cache_attr, rd_share_domain, ar_id, r_ready,
        output aw_ready, w_ready, b_valid, wr_resp, b_id, ar_ready, r_valid, r_data,
        output rd_resp, r_last, r_id
    );
    modport mst (
        output aw_valid, wr_addr, wr_burst_len, wr_cache_attr, wr_txn_type, wr_share_domain,
        output stash_target_enable, stash_target_id, aw_id, w_valid, w_data,
        output wr_byte_strobes, w_last, b_ready, ar_valid, rd_addr, rd_burst_len,
        output rd_cache_attr, rd_share_domain, ar_id, r_ready,
        input aw_ready, w_ready, b_valid, wr_resp, b_id, ar_ready, r_valid, r_data,
        input rd_resp, r_last, r_id
    );
endinterface : cap_if
`default_nettype wire

// file: cap_accel_master.sv
// accelerator end of the port
`timescale 1ns/100ps
`default_nettype none
module cap_accel_master (
    input wire logic clk, // system clock
    input wire logic srst, // synchronous reset, active high
    cap_if.mst port, // port side
    input wire logic req_valid, // user request valid
    output logic req_ready, // request accepted
    input wire logic req_write, // 1 write, 0 read
    input wire logic [cap_pkg::CAP_ADDR_W-1:0] req_addr, // line address
    input wire logic req_line, // 1 for 64-byte, 0 for 16-byte
    input wire logic [3:0] req_type, // write transaction type
    input wire logic [3:0] req_attr, // cache attribute
    input wire logic req_tgt_en, // direct stash to a core
    input wire logic [2:0] req_core, // target core
    input wire logic [cap_pkg::CAP_ID_W-1:0] req_id, // transaction id
    input wire logic wd_valid, // user write beat valid
    output logic wd_ready, // buffer can take beat
    input wire logic [cap_pkg::CAP_DATA_W-1:0] wd_data, // write beat
    input wire logic [cap_pkg::CAP_STRB_W-1:0] wd_strb, // beat strobes
    input wire logic wd_last, // final beat
    output logic done_valid, // response pulse
    output logic [1:0] done_resp, // response code
    output logic [cap_pkg::CAP_DATA_W-1:0] rd_data_out, // read beat data
    output logic rd_beat_valid // read beat pulse
);
    import cap_pkg::*;
    localparam int BW = CAP_DATA_W + CAP_STRB_W + 1;

    logic busy_r, aw_pend_r, ar_pend_r;
    logic [BW-1:0] buf_r [CAP_BUF_DEPTH];
    logic [1:0] cnt_r;
    logic rp_r, wp_r;
    logic push, pop;

    // one transaction in flight
    assign req_ready = !busy_r;
    assign port.aw_valid = aw_pend_r;
    assign port.ar_valid = ar_pend_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            busy_r <= 1'b0;
            aw_pend_r <= 1'b0;
            ar_pend_r <= 1'b0;
            port.wr_addr <= '0;
            port.rd_addr <= '0;
            port.wr_burst_len <= '0;
            port.rd_burst_len <= '0;
            port.wr_cache_attr <= CAP_ATTR_C;
            port.rd_cache_attr <= CAP_ATTR_C;
            port.wr_txn_type <= '0;
            port.stash_target_enable <= 1'b0;
            port.stash_target_id <= '0;
            port.aw_id <= '0;
            port.ar_id <= '0;
        end else begin
            if (req_valid && req_ready) begin
                busy_r <= 1'b1;
                aw_pend_r <= req_write;
                ar_pend_r <= !req_write;
                port.wr_addr <= req_addr;
                port.rd_addr <= req_addr;
                port.wr_burst_len <= req_line ? CAP_LEN_FOUR : CAP_LEN_ONE;
                port.rd_burst_len <= req_line ? CAP_LEN_FOUR : CAP_LEN_ONE;
                port.wr_cache_attr <= req_attr;
                port.rd_cache_attr <= req_attr;
                port.wr_txn_type <= req_type;
                port.stash_target_enable <= req_tgt_en;
                port.stash_target_id <= {req_core, 1'b0};
                port.aw_id <= req_id;
                port.ar_id <= req_id;
            end
            if (port.aw_valid && port.aw_ready) begin
                aw_pend_r <= 1'b0;
            end
            if (port.ar_valid && port.ar_ready) begin
                ar_pend_r <= 1'b0;
            end
            if ((port.b_valid && port.b_ready) || (port.r_valid && port.r_ready && port.r_last)) begin
                busy_r <= 1'b0;
            end
        end
    end

    // two-entry write data buffer
    assign wd_ready = cnt_r != 2'(CAP_BUF_DEPTH);
    assign push = wd_valid && wd_ready;
    assign pop = port.w_valid && port.w_ready;
    assign port.w_valid = cnt_r != 2'h0;
    assign {port.w_data, port.wr_byte_strobes, port.w_last} = buf_r[rp_r];
    assign port.b_ready = 1'b1;
    assign port.r_ready = 1'b1;
    assign port.wr_share_domain = 2'h0;
    assign port.rd_share_domain = 2'h0;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
            rp_r <= 1'b0;
            wp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
            if (push) begin
                wp_r <= !wp_r;
            end
            if (pop) begin
                rp_r <= !rp_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            buf_r[wp_r] <= {wd_data, wd_strb, wd_last};
        end
    end

    // response and read data capture
    always_ff @(posedge clk) begin
        if (srst) begin
            done_valid <= 1'b0;
            done_resp <= '0;
            rd_data_out <= '0;
            rd_beat_valid <= 1'b0;
        end else begin
            done_valid <= port.b_valid || (port.r_valid && port.r_last);
            done_resp <= port.b_valid ? port.wr_resp : port.rd_resp;
            rd_data_out <= port.r_data;
            rd_beat_valid <= port.r_valid;
        end
    end
endmodule : cap_accel_master
`default_nettype wire

// file: cap_port_checker.sv
// assertions on the accelerator port interface
`timescale 1ns/100ps
`default_nettype none
module cap_port_checker (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    input wire logic aw_valid, // aw valid
    input wire logic aw_ready, // aw ready
    input wire logic [cap_pkg::CAP_ADDR_W-1:0] wr_addr, // write address
    input wire logic [cap_pkg::CAP_LEN_W-1:0] wr_burst_len, // write length
    input wire logic [3:0] wr_cache_attr, // write attribute
    input wire logic [3:0] wr_txn_type, // write type
    input wire logic w_valid, // w valid
    input wire logic w_ready, // w ready
    input wire logic w_last, // last beat
    input wire logic b_valid, // b valid
    input wire logic b_ready, // b ready
    input wire logic [1:0] wr_resp, // write response
    input wire logic ar_valid, // ar valid
    input wire logic ar_ready, // ar ready
    input wire logic [cap_pkg::CAP_ADDR_W-1:0] rd_addr, // read address
    input wire logic [cap_pkg::CAP_LEN_W-1:0] rd_burst_len, // read length
    input wire logic [3:0] rd_cache_attr, // read attribute
    input wire logic r_valid, // r valid
    input wire logic r_ready, // r ready
    input wire logic [cap_pkg::CAP_DATA_W-1:0] r_data, // read data
    input wire logic [1:0] rd_resp, // read response
    input wire logic r_last // last beat
);
    import cap_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // address phases
    wire ar_t = ar_valid && ar_ready;
    wire aw_t = aw_valid && aw_ready;
    wire rd_at = rd_cache_attr inside {CAP_ATTR_A, CAP_ATTR_B, CAP_ATTR_C};
    wire wr_at = wr_cache_attr inside {CAP_ATTR_A, CAP_ATTR_B, CAP_ATTR_C};
    wire rd_ok = rd_at && (rd_burst_len == CAP_LEN_ONE && rd_addr[3:0] == 4'h0
        || rd_burst_len == CAP_LEN_FOUR && rd_addr[5:0] == 6'h00);
    wire once = (wr_txn_type == 4'hC || wr_txn_type == 4'hD) && wr_at
        && wr_burst_len == CAP_LEN_FOUR && wr_addr[5:0] == 6'h00;
    a_rd_err_resp: assert property (ar_t && !rd_ok |=> r_valid && rd_resp == CAP_RESP_SLVERR)
        else $error("illegal read not refused");
    a_rd_ok_resp: assert property (ar_t && rd_ok |=> r_valid && rd_resp == CAP_RESP_OKAY)
        else $error("legal read refused");
    a_rd_one_beat: assert property (ar_t && rd_burst_len == CAP_LEN_ONE |=> r_last)
        else $error("single read not last");
    a_rd_four_beat: assert property (ar_t && rd_burst_len == CAP_LEN_FOUR |=> !r_last)
        else $error("line read ended early");
    a_wr_attr_err: assert property (aw_t && !wr_at |-> ##[1:40] b_valid && wr_resp == CAP_RESP_SLVERR)
        else $error("bad write attribute not refused");
    a_b_after_last: assert property (w_valid && w_ready && w_last |-> ##[1:3] b_valid)
        else $error("write response late");
    a_b_hold: assert property (b_valid && !b_ready |=> b_valid && $stable(wr_resp))
        else $error("write response dropped");
    a_r_hold: assert property (r_valid && !r_ready |=> r_valid && $stable(r_data))
        else $error("read beat dropped");
    a_aw_busy: assert property (aw_t |=> !aw_ready)
        else $error("write taken while busy");
    a_dataless_ok: assert property (aw_t && once |=> b_valid && wr_resp == CAP_RESP_OKAY)
        else $error("dataless stash not answered");
    // covers
    c_line_read: cover property (ar_t && rd_burst_len == CAP_LEN_FOUR);
    c_full_stash: cover property (aw_t && wr_txn_type == 4'h9);
    c_wr_err: cover property (b_valid && wr_resp == CAP_RESP_SLVERR);
endmodule : cap_port_checker
`default_nettype wire

// file: test_coherent_accel_slave_port.sv
// self-checking bench joining both ends
`timescale 1ns/100ps
`default_nettype none
module test_coherent_accel_slave_port;
    import cap_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0, req_write = 1'b0, req_line = 1'b0, req_tgt_en = 1'b0, req_ready;
    logic [CAP_ADDR_W-1:0] req_addr = '0, lookup_addr, wr_commit_addr, lk_addr, c_addr;
    logic [3:0] req_type = 4'h0, req_attr = 4'hF;
    logic [2:0] req_core = 3'h0, wr_commit_core, c_core;
    logic [CAP_ID_W-1:0] req_id = '0;
    logic wd_valid = 1'b0, wd_last = 1'b0, wd_ready, done_valid, rd_beat_valid;
    logic [CAP_DATA_W-1:0] wd_data = '0, mem_rd_data = '0, rd_data_out, exp_rd;
    logic [CAP_STRB_W-1:0] wd_strb = '0;
    logic [1:0] done_resp;
    logic lookup_valid, wr_commit_valid, wr_commit_rmw, c_rmw, c_seen, lk_seen;
    cap_dest_t wr_commit_dest, c_dest;
    logic [5:0] rd_outstanding, wr_outstanding;
    int fails = 0, n_compared = 0, cyc = 0, beats = 0;
    logic [3:0] tys [7] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hC, 4'hD, 4'h3};
    logic [3:0] ats [5] = '{4'h7, 4'hB, 4'hF, 4'h3, 4'h6};
    cap_if bus ();
    cap_slave_port cap_slave_port_i (.clk, .srst, .port(bus), .lookup_valid, .lookup_addr,
        .wr_commit_valid, .wr_commit_addr, .wr_commit_dest, .wr_commit_core, .wr_commit_rmw,
        .mem_rd_data, .rd_outstanding, .wr_outstanding);
    cap_accel_master cap_accel_master_i (.clk, .srst, .port(bus), .req_valid, .req_ready,
        .req_write, .req_addr, .req_line, .req_type, .req_attr, .req_tgt_en, .req_core, .req_id,
        .wd_valid, .wd_ready, .wd_data, .wd_strb, .wd_last, .done_valid, .done_resp,
        .rd_data_out, .rd_beat_valid);
    cap_port_checker cap_port_checker_i (.clk, .srst, .aw_valid(bus.aw_valid),
        .aw_ready(bus.aw_ready), .wr_addr(bus.wr_addr), .wr_burst_len(bus.wr_burst_len),
        .wr_cache_attr(bus.wr_cache_attr), .wr_txn_type(bus.wr_txn_type), .w_valid(bus.w_valid),
        .w_ready(bus.w_ready), .w_last(bus.w_last), .b_valid(bus.b_valid), .b_ready(bus.b_ready),
        .wr_resp(bus.wr_resp), .ar_valid(bus.ar_valid), .ar_ready(bus.ar_ready),
        .rd_addr(bus.rd_addr), .rd_burst_len(bus.rd_burst_len), .rd_cache_attr(bus.rd_cache_attr),
        .r_valid(bus.r_valid), .r_ready(bus.r_ready), .r_data(bus.r_data),
        .rd_resp(bus.rd_resp), .r_last(bus.r_last));
    // clock of 10 ns
    initial begin
        forever #5 clk = ~clk;
    end
    // comparison with mismatch report
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // counts and verdict, then stop
    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    // expected response
    function automatic logic [1:0] exp_resp(logic w, logic [39:0] a, logic ln, logic [3:0] t,
        logic [3:0] at, logic full);
        logic ok;
        ok = at inside {CAP_ATTR_A, CAP_ATTR_B, CAP_ATTR_C}
            && (ln ? a[5:0] == 6'h00 : a[3:0] == 4'h0);
        if (w) ok = ok && (t == 4'h0 || t == 4'h8 || ln && (t == 4'h1 || t >= 4'h9))
            && (full || !(t == 4'h1 || t == 4'h9));
        return ok ? CAP_RESP_OKAY : CAP_RESP_SLVERR;
    endfunction : exp_resp
    // watchdog
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("CHECK FAILED at %0t: timeout", $time);
            give_verdict();
        end
    end
    // monitors
    always @(negedge clk) begin
        if (rd_beat_valid) begin
            beats++;
            chk(rd_data_out, exp_rd);
        end
        if (lookup_valid) {lk_seen, lk_addr} = {1'b1, lookup_addr};
        if (wr_commit_valid) {c_seen, c_addr, c_core, c_rmw} = {1'b1, wr_commit_addr, wr_commit_core, wr_commit_rmw};
        if (wr_commit_valid) c_dest = wr_commit_dest;
    end
    // one transfer, then its outcomes compared
    task automatic run(input logic w, input logic [39:0] a, input logic ln, input logic [3:0] t,
        input logic [3:0] at, input logic full);
        logic [1:0] er;
        logic tg;
        int k;
        tg = w && 1'($urandom) && (t == 4'h9 || t >= 4'hC);
        er = exp_resp(w, a, ln, t, at, full);
        mem_rd_data = {$urandom, $urandom, $urandom, $urandom};
        exp_rd = er == CAP_RESP_OKAY ? mem_rd_data : '0;
        {req_write, req_addr, req_line, req_type, req_attr, req_tgt_en} = {w, a, ln, t, at, tg};
        {req_core, req_id} = 9'($urandom);
        {req_valid, c_seen, lk_seen, beats} = {3'b100, 32'h0};
        while (!req_ready) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (k = 0; w && t < 4'hC && k < (ln ? 4 : 1); k++) begin
            {wd_valid, wd_last, wd_data} = {1'b1, k == (ln ? 3 : 0), $urandom, $urandom, $urandom, $urandom};
            wd_strb = full ? CAP_STRB_ALL : {1'b0, 15'($urandom)};
            while (!wd_ready) @(negedge clk);
            @(negedge clk);
        end
        wd_valid = 1'b0;
        for (k = 0; k < 200 && !done_valid; k++) @(negedge clk);
        chk(done_valid, 1'b1);
        chk(done_resp, er);
        repeat (3) @(negedge clk);
        chk({rd_outstanding, wr_outstanding}, 12'h000);
        if (!w) chk(beats, ln ? 4 : 1);
        if (er == CAP_RESP_OKAY) chk({lk_seen, lk_addr[39:6]}, {1'b1, a[39:6]});
        if (w) chk(c_seen, er == CAP_RESP_OKAY);
        if (w && er == CAP_RESP_OKAY) begin
            chk(c_dest, tg ? CAP_DEST_CORE : at[3] ? CAP_DEST_SHARED : CAP_DEST_MEMORY);
            chk(c_rmw, t == 4'h0 || t == 4'h8);
            chk(c_addr, a);
            if (tg) chk(c_core, req_core);
        end
    endtask : run
    // reset, then the three tests
    initial begin
        void'($urandom(46));
        repeat (12) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        foreach (ats[i]) for (int ln = 0; ln < 2; ln++) for (int o = 0; o < 2; o++)
            run(1'b0, {34'($urandom), o ? 6'h10 : 6'h00}, 1'(ln), 4'h0, ats[i], 1'b1);
        $display("test reads done");
        foreach (tys[j]) foreach (ats[i]) for (int m = 0; m < 4; m++)
            run(1'b1, {34'($urandom), 6'h00}, m[0], tys[j], ats[i], m[1]);
        $display("test write types done");
        repeat (60) run(1'($urandom), {34'($urandom), ($urandom_range(0, 3) == 0) ? 6'h10 : 6'h00},
            1'($urandom), tys[$urandom_range(0, 6)], ats[$urandom_range(0, 4)], 1'($urandom));
        $display("test random mix done");
        give_verdict();
    end
endmodule : test_coherent_accel_slave_port
`default_nettype wire
